// [hdl/sci_defines.svh]
// register offsets, field layouts and reset values of the clock event interrupt block
`ifndef SCI_DEFINES_SVH
`define SCI_DEFINES_SVH

`define SCI_ADDR_W        8
`define SCI_NUM_SRC       12
`define SCI_OFF_EN_SET    8'h04
`define SCI_OFF_FLAGS     8'h08
`define SCI_OFF_STATUS    8'h0c
`define SCI_OFF_BUS_EVT   8'h10
`define SCI_OFF_BUS_MASK  8'h14
`define SCI_RST_FLAGS     32'h0000_0000
`define SCI_RST_STATUS    32'h0000_0000
`define SCI_RST_EN        12'h000
`define SCI_RST_BUS       2'h0
`define SCI_BIT_CRYSTAL   0
`define SCI_BIT_SLOW_XTAL 1
`define SCI_BIT_SLOW_RC   2
`define SCI_BIT_FAST_RC   3
`define SCI_BIT_FLL_RDY   4
`define SCI_BIT_FLL_OOB   5
`define SCI_BIT_FLL_FINE  6
`define SCI_BIT_FLL_COARS 7
`define SCI_BIT_FLL_REFST 8
`define SCI_BIT_BO_READY  9
`define SCI_BIT_BO_DETECT 10
`define SCI_BIT_BO_SYNC   11
`define SCI_BUS_UNMAPPED  0
`define SCI_BUS_RSVD_WR   1

`endif

// [hdl/sci_pkg.sv]
// types shared by the clock event interrupt block
package sci_pkg;

	// one bit per clock or supply source, flag layout
	typedef logic [11:0] sci_src_t;

	// two sticky bus events: unmapped access, reserved flag bits written
	typedef logic [1:0] sci_bus_evt_t;

	// decoded register select
	typedef enum logic [2:0] {
		SCI_SEL_NONE     = 3'b000,
		SCI_SEL_EN_SET   = 3'b001,
		SCI_SEL_FLAGS    = 3'b010,
		SCI_SEL_STATUS   = 3'b011,
		SCI_SEL_BUS_EVT  = 3'b100,
		SCI_SEL_BUS_MASK = 3'b101
	} sci_sel_t;

endpackage : sci_pkg

// [hdl/sci_clock_irq_flags.sv]
// clock and supply event flags, enables and interrupt request of the system controller
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "sci_defines.svh"

module sci_clock_irq_flags
	import sci_pkg::*;
#(
	parameter int ADDR_W  = `SCI_ADDR_W,
	parameter int NUM_SRC = `SCI_NUM_SRC
) (
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic [11:0]       src_status_i,
	output logic      [31:0]       rdata_o,
	output logic                   irq_o
);

	// the layout is fixed to twelve sources and byte offsets up to 0x14
	if (NUM_SRC != 12 || ADDR_W < 5) begin : g_param_check
		$error("sci_clock_irq_flags: NUM_SRC must be 12 and ADDR_W at least 5");
	end

	sci_src_t     sync1_reg;
	sci_src_t     status_reg;
	sci_src_t     status_prev_reg;
	sci_src_t     flags_reg;
	sci_src_t     flags_next;
	sci_src_t     en_reg;
	sci_src_t     en_next;
	sci_src_t     rise;
	sci_src_t     flag_clr;
	sci_bus_evt_t bus_evt_reg;
	sci_bus_evt_t bus_evt_next;
	sci_bus_evt_t bus_mask_reg;
	sci_bus_evt_t bus_mask_next;
	sci_bus_evt_t bus_set;
	sci_sel_t     sel;
	logic [31:0]  rdata_reg;
	logic         irq_reg;

	// address decode of the register window
	always_comb begin
		if (addr_i == ADDR_W'(`SCI_OFF_EN_SET)) begin
			sel = SCI_SEL_EN_SET;
		end else if (addr_i == ADDR_W'(`SCI_OFF_FLAGS)) begin
			sel = SCI_SEL_FLAGS;
		end else if (addr_i == ADDR_W'(`SCI_OFF_STATUS)) begin
			sel = SCI_SEL_STATUS;
		end else if (addr_i == ADDR_W'(`SCI_OFF_BUS_EVT)) begin
			sel = SCI_SEL_BUS_EVT;
		end else if (addr_i == ADDR_W'(`SCI_OFF_BUS_MASK)) begin
			sel = SCI_SEL_BUS_MASK;
		end else begin
			sel = SCI_SEL_NONE;
		end
	end

	// status bits come from other clock domains: two flops before any use
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_reg  <= sci_src_t'(`SCI_RST_STATUS);
			status_reg <= sci_src_t'(`SCI_RST_STATUS);
		end else begin
			sync1_reg  <= src_status_i;
			status_reg <= sync1_reg;
		end
	end

	// previous synchronised level, for edge detection
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_prev_reg <= sci_src_t'(`SCI_RST_STATUS);
		end else begin
			status_prev_reg <= status_reg;
		end
	end

	assign rise = status_reg & ~status_prev_reg;

	assign flag_clr = (wr_i && sel == SCI_SEL_FLAGS) ? wdata_i[11:0] : '0;

	// set applied after clear so a same-cycle edge survives
	assign flags_next = (flags_reg & ~flag_clr) | rise;

	// enables are set-only; a zero bit keeps the old value
	assign en_next = (wr_i && sel == SCI_SEL_EN_SET) ? (en_reg | wdata_i[11:0]) : en_reg;

	// flag register, twelve sources in layout order
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_reg <= sci_src_t'(`SCI_RST_FLAGS);
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_reg <= `SCI_RST_EN;
		end else begin
			en_reg <= en_next;
		end
	end

	// bus misuse events; software stray writes are otherwise invisible
	always_comb begin
		bus_set = '0;
		bus_set[`SCI_BUS_UNMAPPED] = (wr_i || rd_i) && sel == SCI_SEL_NONE;
		// software misuse of the reserved flag bits is recorded
		bus_set[`SCI_BUS_RSVD_WR] = wr_i && sel == SCI_SEL_FLAGS && (|wdata_i[31:12]);
	end

	// sticky, cleared by a read; a same-cycle event still lands
	assign bus_evt_next = ((rd_i && sel == SCI_SEL_BUS_EVT) ? '0 : bus_evt_reg) | bus_set;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_evt_reg <= `SCI_RST_BUS;
		end else begin
			bus_evt_reg <= bus_evt_next;
		end
	end

	// mask of the bus events, plain read/write; its next value feeds the
	// request so that a mask write and the request change on one edge
	assign bus_mask_next = (wr_i && sel == SCI_SEL_BUS_MASK) ? wdata_i[1:0] : bus_mask_reg;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_mask_reg <= `SCI_RST_BUS;
		end else begin
			bus_mask_reg <= bus_mask_next;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_i) begin
			case (sel)
				SCI_SEL_EN_SET:   rdata_reg <= {20'h00000, en_reg};
				// reserved flag bits read as zero
				SCI_SEL_FLAGS:    rdata_reg <= {20'h00000, flags_reg};
				SCI_SEL_STATUS:   rdata_reg <= {20'h00000, status_reg};
				SCI_SEL_BUS_EVT:  rdata_reg <= {30'h00000000, bus_evt_reg};
				SCI_SEL_BUS_MASK: rdata_reg <= {30'h00000000, bus_mask_reg};
				default:          rdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	// request from next state, so it follows the flags with no lag
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (|(flags_next & en_next)) | (|(bus_evt_next & bus_mask_next));
		end
	end

	assign rdata_o = rdata_reg;
	assign irq_o   = irq_reg;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	// enable-set write takes effect next cycle
	chk_enable_set_w1s: assert property (
		(wr_i && sel == SCI_SEL_EN_SET)
			|=> en_reg == ($past(en_reg) | $past(wdata_i[11:0])))
		else $error("enable set write did not or-in the written ones");

	// no request without an enabled flag or masked bus event
	chk_irq_masked_off: assert property (
		((flags_reg & en_reg) == '0 && (bus_evt_reg & bus_mask_reg) == '0) |-> !irq_o)
		else $error("request raised with no enabled flag");

	// enabled set flag holds the request up
	chk_irq_enabled_on: assert property (
		(|(flags_reg & en_reg)) |-> irq_o)
		else $error("enabled flag set but no request");

	// flag read returns flags with upper bits zero
	chk_flag_read_data: assert property (
		(rd_i && sel == SCI_SEL_FLAGS) |=> rdata_o == {20'h00000, $past(flags_reg)})
		else $error("flag read returned wrong data");

	// a source edge sets its flag in the cycle after the synchronised rise
	chk_flag_edge_set: assert property (
		(rise != '0) |=> ((flags_reg & $past(rise)) == $past(rise)))
		else $error("rising status edge did not set flag");

	// a flag only appears from an edge, never from a steady level
	chk_flag_no_level: assert property (
		##1 ((flags_reg & ~$past(flags_reg) & ~$past(rise)) == '0))
		else $error("flag set without a rising edge");

	// a written one clears unless an edge came at once
	chk_flag_w1c_clear: assert property (
		(flag_clr != '0) |=> ((flags_reg & $past(flag_clr) & ~$past(rise)) == '0))
		else $error("write one did not clear flag");

	// a flag never drops without a written one
	chk_flag_hold_zero: assert property (
		##1 (($past(flags_reg) & ~flags_reg & ~$past(flag_clr)) == '0))
		else $error("flag dropped without a clear");

	// status read shows the synchronised levels
	chk_status_read: assert property (
		(rd_i && sel == SCI_SEL_STATUS) |=> rdata_o == {20'h00000, $past(status_reg)})
		else $error("status read returned wrong data");

	// edge in the same cycle as a clear keeps the flag set
	chk_set_beats_clr: assert property (
		(flag_clr != '0 && (rise & flag_clr) != '0)
			|=> ((flags_reg & $past(rise)) == $past(rise)) ##1 1'b1)
		else $error("clear won over a same-cycle edge");

	// further checks; the request is registered from next values, so it
	// must agree with the registers in the very cycle they change
	// enable bits never fall outside reset
	chk_enable_no_drop: assert property (
		##1 (($past(en_reg) & ~en_reg) == '0))
		else $error("enable bit dropped without reset");

	// enable read returns the twelve enables, upper bits zero
	chk_en_read_data: assert property (
		(rd_i && sel == SCI_SEL_EN_SET) |=> rdata_o == {20'h00000, $past(en_reg)})
		else $error("enable read returned wrong data");

	// no read ever shows a bit above the twelve sources
	chk_rsvd_read_zero: assert property (
		rdata_o[31:12] == 20'h00000)
		else $error("reserved read data bits not zero");

	// read data fall back to zero when no read was taken
	chk_rdata_idle_zero: assert property (
		!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data not zero outside a read");

	// an unmasked bus event also holds the request up
	chk_irq_bus_event: assert property (
		((bus_evt_reg & bus_mask_reg) != '0) |-> irq_o)
		else $error("unmasked bus event but no request");

	// request is exactly the or of enabled flags and unmasked bus events
	chk_irq_exact: assert property (
		irq_o == ((|(flags_reg & en_reg)) || (|(bus_evt_reg & bus_mask_reg))))
		else $error("request differs from enabled flags");

	// an enable only rises at a write to the enable-set register
	chk_en_set_by_write: assert property (
		##1 ((en_reg & ~$past(en_reg)) == '0
			|| ($past(wr_i) && $past(sel) == SCI_SEL_EN_SET)))
		else $error("enable rose without an enable-set write");

	chk_unmapped_rd_zero: assert property (
		(rd_i && sel == SCI_SEL_NONE) |=> rdata_o == 32'h0000_0000)
		else $error("unmapped read returned non-zero data");

	// an unmapped access records a bus event
	chk_unmapped_event: assert property (
		((wr_i || rd_i) && sel == SCI_SEL_NONE) |=> bus_evt_reg[`SCI_BUS_UNMAPPED])
		else $error("unmapped access not recorded");

	// reading the bus events clears them when nothing new arrives
	chk_bus_evt_clear: assert property (
		(rd_i && sel == SCI_SEL_BUS_EVT && bus_set == '0) |=> bus_evt_reg == '0)
		else $error("bus event read did not clear");

	// a flag clear leaves every other flag as it was unless a same-cycle edge sets it
	chk_w1c_keeps_others: assert property (
		(flag_clr != '0) |=> ((flags_reg & ~$past(flag_clr))
			== (($past(flags_reg) | $past(rise)) & ~$past(flag_clr))))
		else $error("flag clear disturbed another flag");

	// an edge on an enabled source raises the request with its flag
	chk_edge_irq: assert property (
		(|(rise & en_reg)) |=> irq_o)
		else $error("enabled edge did not raise the request");

endmodule : sci_clock_irq_flags

// [sim/sci_clock_irq_flags_bench.sv]
// self-checking bench for the clock event flag and interrupt block
`timescale 1ns/1ps
`include "sci_defines.svh"
module sci_clock_irq_flags_bench
	import sci_pkg::*;
;
	logic        clock_i;
	logic        nrst_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	sci_src_t    src_status_i;
	logic [31:0] rdata_o;
	logic        irq_o;
	int          errors;
	int          compares;
	int          cycles;

	sci_clock_irq_flags dut (
		.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .src_status_i(src_status_i),
		.rdata_o(rdata_o), .irq_o(irq_o)
	);

	// 125 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			close_out();
		end
	end

	task automatic close_out;
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : wait_cyc

	// one-cycle write strobe, taken at the second edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : bus_wr

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(what, rdata_o, exp);
	endtask : rd_chk

	task automatic reset_values;
		chk("irq", {31'h0, irq_o}, 32'h0);
		rd_chk(`SCI_OFF_FLAGS, 32'h0, "flags");
		rd_chk(`SCI_OFF_STATUS, 32'h0, "status");
		rd_chk(`SCI_OFF_EN_SET, 32'h0, "enables");
	endtask : reset_values

	// unmapped access raises the masked bus event request; a read clears it
	task automatic bus_events;
		bus_wr(`SCI_OFF_BUS_MASK, 32'h1);
		rd_chk(`SCI_OFF_BUS_MASK, 32'h1, "bus mask");
		rd_chk(8'h3c, 32'h0, "unmapped");
		chk("irq", {31'h0, irq_o}, 32'h1);
		rd_chk(`SCI_OFF_BUS_EVT, 32'h1, "bus events");
		chk("irq", {31'h0, irq_o}, 32'h0);
		rd_chk(`SCI_OFF_BUS_EVT, 32'h0, "bus events");
		bus_wr(`SCI_OFF_BUS_MASK, 32'h0);
	endtask : bus_events

	// raise sources one by one, flags accumulate in bit order
	task automatic edges_set_flags;
		logic [31:0] acc;
		acc = 32'h0;
		for (int k = 0; k < 12; k++) begin
			@(posedge clock_i);
			src_status_i[k] <= 1'b1;
			acc[k] = 1'b1;
			wait_cyc(5);
			rd_chk(`SCI_OFF_STATUS, acc, "status");
			rd_chk(`SCI_OFF_FLAGS, acc, "flags");
		end
		chk("irq", {31'h0, irq_o}, 32'h0);
		bus_wr(`SCI_OFF_FLAGS, 32'h0);
		rd_chk(`SCI_OFF_FLAGS, 32'hfff, "flags");
		bus_wr(8'h3c, 32'hffff_ffff);
		rd_chk(`SCI_OFF_FLAGS, 32'hfff, "flags");
		bus_wr(`SCI_OFF_STATUS, 32'h0);
		rd_chk(`SCI_OFF_STATUS, 32'hfff, "status");
		// clear all twelve; reserved bits kept zero as software must
		bus_wr(`SCI_OFF_FLAGS, 32'h0000_0fff);
		wait_cyc(4);
		rd_chk(`SCI_OFF_FLAGS, 32'h0, "flags");
		rd_chk(`SCI_OFF_FLAGS, 32'h0, "flags");
		@(posedge clock_i);
		src_status_i <= 12'h000;
		wait_cyc(5);
		rd_chk(`SCI_OFF_FLAGS, 32'h0, "flags");
	endtask : edges_set_flags

	// each source held off until enabled, then clear drops the request
	task automatic enables_and_irq;
		logic [31:0] en;
		en = 32'h0;
		for (int k = 0; k < 12; k++) begin
			@(posedge clock_i);
			src_status_i[k] <= 1'b1;
			wait_cyc(5);
			chk("irq", {31'h0, irq_o}, 32'h0);
			bus_wr(`SCI_OFF_EN_SET, 32'h1 << k);
			bus_wr(`SCI_OFF_EN_SET, 32'h0);
			en[k] = 1'b1;
			rd_chk(`SCI_OFF_EN_SET, en, "enables");
			chk("irq", {31'h0, irq_o}, 32'h1);
			bus_wr(`SCI_OFF_FLAGS, 32'h1 << k);
			wait_cyc(1);
			#1 chk("irq", {31'h0, irq_o}, 32'h0);
			@(posedge clock_i);
			src_status_i[k] <= 1'b0;
		end
	endtask : enables_and_irq

	// clear lands on the very edge that sets the flag
	task automatic set_beats_clear;
		wait_cyc(3);
		@(posedge clock_i);
		src_status_i[5] <= 1'b1;
		@(posedge clock_i);
		bus_wr(`SCI_OFF_FLAGS, 32'h20);
		rd_chk(`SCI_OFF_FLAGS, 32'h20, "flags");
		chk("irq", {31'h0, irq_o}, 32'h1);
	endtask : set_beats_clear

	// second reset in mid-run wipes flags and enables
	task automatic reset_again;
		@(posedge clock_i);
		nrst_i       <= 1'b0;
		src_status_i <= 12'h000;
		wait_cyc(2);
		nrst_i <= 1'b1;
		#1 chk("irq", {31'h0, irq_o}, 32'h0);
		rd_chk(`SCI_OFF_FLAGS, 32'h0, "flags");
		rd_chk(`SCI_OFF_EN_SET, 32'h0, "enables");
	endtask : reset_again

	initial begin
		errors       = 0;
		compares     = 0;
		cycles       = 0;
		nrst_i       = 1'b0;
		addr_i       = 8'h00;
		wdata_i      = 32'h0;
		wr_i         = 1'b0;
		rd_i         = 1'b0;
		src_status_i = 12'h000;
		wait_cyc(4);
		nrst_i <= 1'b1;
		reset_values();
		bus_events();
		edges_set_flags();
		enables_and_irq();
		set_beats_clear();
		reset_again();
		close_out();
	end
endmodule : sci_clock_irq_flags_bench
